// *** hdl/branch_condition_and_int_ack.sv ***
/*
 Execution logic for conditional branches and interrupt acknowledge.
 Assumes a sequencer issues one instruction with exec_valid, supplies the index register
 contents, and that the peripheral bus answers an acknowledge request with ack_done.
 Index register zero reads as zero, which the sequencer supplies.
*/
`timescale 1ns/1ps

module branch_condition_and_int_ack (
   // Clock and reset
   input  wire logic                            clock,
   input  wire logic                            rstn,
   // Instruction issue
   input  wire logic                            exec_valid,
   input  wire branch_ack_pkg::instr_type       instr,
   input  wire logic [15:0]                     index_value,
   // Status word load from the sequencer
   input  wire logic                            status_load,
   input  wire branch_ack_pkg::status_word_type status_in,
   // Peripheral acknowledge handshake
   output logic                                 ack_req,
   input  wire logic                            ack_done,
   input  wire branch_ack_pkg::ack_reply_type   ack_reply,
   output logic                                 int_clear,
   // Branch results
   output branch_ack_pkg::status_word_type      program_status_word,
   output logic                                 exec_done,
   output logic                                 branch_taken,
   // Acknowledge results
   output logic                                 reg1_we,
   output logic [15:0]                          reg1_data,
   output logic                                 reg2_we,
   output logic                                 mem_we,
   output logic [15:0]                          op2_addr,
   output logic [15:0]                          op2_data
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      idle_st,
      ack_wait_st,
      clear_st
   } state_type;

   // Sequencer and status word
   state_type                       state_q;
   state_type                       state_d;
   branch_ack_pkg::status_word_type status_q;
   branch_ack_pkg::status_word_type status_d;
   logic [3:0]                      flags_d;
   logic [15:0]                     addr_d;

   // Acknowledge context
   logic                            indexed_q;
   logic                            indexed_d;
   logic [15:0]                     ea_q;
   logic [15:0]                     ea_d;
   logic                            ack_req_q;
   logic                            ack_req_d;
   logic                            int_clear_q;
   logic                            int_clear_d;

   // Result pulses and words
   logic                            done_q;
   logic                            done_d;
   logic                            taken_q;
   logic                            taken_d;
   logic                            reg1_we_q;
   logic                            reg1_we_d;
   logic                            reg2_we_q;
   logic                            reg2_we_d;
   logic                            mem_we_q;
   logic                            mem_we_d;
   logic [15:0]                     reg1_data_q;
   logic [15:0]                     reg1_data_d;
   logic [15:0]                     op2_addr_q;
   logic [15:0]                     op2_addr_d;
   logic [15:0]                     op2_data_q;
   logic [15:0]                     op2_data_d;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire logic [3:0]  flags      = status_q.condition_flags;
   wire logic [3:0]  mask       = instr.mask_field;
   wire logic        is_true    = instr.opcode == branch_ack_pkg::op_branch_true;
   wire logic        is_false   = instr.opcode == branch_ack_pkg::op_branch_false;
   wire logic        is_ack_reg = instr.opcode == branch_ack_pkg::op_ack_reg;
   wire logic        is_ack_idx = instr.opcode == branch_ack_pkg::op_ack_indexed;
   wire logic        is_ack     = is_ack_reg | is_ack_idx;

   // ----------------------------------------------------------------
   // Condition test, one lane per flag
   // ----------------------------------------------------------------
   wire logic [3:0]  selected;
   wire logic [3:0]  status_flags;

   for (genvar lane = 0; lane < 4; lane++) begin : g_lane
      // A lane joins the test only where its mask bit is set
      assign selected[lane]     = flags[lane] & mask[lane];
      // Status nibble lands bit for bit on C V G L, busy highest
      assign status_flags[lane] = ack_reply.status_byte[lane];
   end

   // One test covers every named mask; a zero mask on the true form never branches
   wire logic        cond_true  = |selected;
   wire logic        cond_false = ~|selected;
   wire logic        take       = (is_true & cond_true) | (is_false & cond_false);

   // ----------------------------------------------------------------
   // Addresses and reply words
   // ----------------------------------------------------------------
   wire logic [15:0] eff_addr   = instr.displacement + index_value;
   wire logic [15:0] seq_addr   = status_q.instr_addr + branch_ack_pkg::next_instr_step;
   wire logic [15:0] dev_word   = {branch_ack_pkg::upper_byte_zero, ack_reply.device_number};
   wire logic [15:0] stat_word  = {branch_ack_pkg::upper_byte_zero, ack_reply.status_byte};

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   wire logic        idle       = state_q == idle_st;
   wire logic        waiting    = state_q == ack_wait_st;
   wire logic        clearing   = state_q == clear_st;
   wire logic        start      = exec_valid & idle;
   wire logic        branch_go  = start & (is_true | is_false);
   wire logic        ack_go     = start & is_ack;
   wire logic        answered   = waiting & ack_done;

   always_comb begin
      state_d = state_q;
      case (state_q)
         idle_st: begin
            if (ack_go) begin
               state_d = ack_wait_st;
            end
         end
         ack_wait_st: begin
            if (ack_done) begin
               state_d = clear_st;
            end
         end
         clear_st: begin
            state_d = idle_st;
         end
         default: begin
            state_d = idle_st;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   // A load beside an issue keeps the decision on the old flags
   always_comb begin
      flags_d = status_q.condition_flags;
      if (idle && status_load) begin
         flags_d = status_in.condition_flags;
      end
      if (answered) begin
         flags_d = status_flags;
      end
   end

   always_comb begin
      addr_d = status_q.instr_addr;
      if (idle && status_load) begin
         addr_d = status_in.instr_addr;
      end
      if (branch_go) begin
         addr_d = take ? eff_addr : seq_addr;
      end else if (answered) begin
         addr_d = seq_addr;
      end
   end

   assign status_d = {flags_d, addr_d};

   // ----------------------------------------------------------------
   // Acknowledge context next values
   // ----------------------------------------------------------------
   assign indexed_d   = ack_go ? is_ack_idx : indexed_q;
   assign ea_d        = ack_go ? eff_addr : ea_q;
   // Request held until the device answers
   assign ack_req_d   = ack_go | (waiting & ~ack_done);
   // Clear raised in the same cycle as the number and status write pulses
   assign int_clear_d = answered;

   // ----------------------------------------------------------------
   // Result next values
   // ----------------------------------------------------------------
   assign done_d      = branch_go | clearing;
   assign taken_d     = branch_go & take;
   assign reg1_we_d   = answered;
   assign reg2_we_d   = answered & ~indexed_q;
   assign mem_we_d    = answered & indexed_q;

   assign reg1_data_d = answered ? dev_word : reg1_data_q;
   assign op2_addr_d  = answered ? ea_q : op2_addr_q;
   assign op2_data_d  = answered ? stat_word : op2_data_q;

   // ----------------------------------------------------------------
   // Sequencer registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= idle_st;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         status_q <= '{branch_ack_pkg::flags_reset, branch_ack_pkg::addr_reset};
      end else begin
         status_q <= status_d;
      end
   end

   // ----------------------------------------------------------------
   // Acknowledge context registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         indexed_q <= 1'b0;
      end else begin
         indexed_q <= indexed_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ea_q <= 16'h0000;
      end else begin
         ea_q <= ea_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ack_req_q <= 1'b0;
      end else begin
         ack_req_q <= ack_req_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         int_clear_q <= 1'b0;
      end else begin
         int_clear_q <= int_clear_d;
      end
   end

   // ----------------------------------------------------------------
   // Result pulse registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         done_q <= 1'b0;
      end else begin
         done_q <= done_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         taken_q <= 1'b0;
      end else begin
         taken_q <= taken_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reg1_we_q <= 1'b0;
      end else begin
         reg1_we_q <= reg1_we_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reg2_we_q <= 1'b0;
      end else begin
         reg2_we_q <= reg2_we_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mem_we_q <= 1'b0;
      end else begin
         mem_we_q <= mem_we_d;
      end
   end

   // ----------------------------------------------------------------
   // Result word registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reg1_data_q <= 16'h0000;
      end else begin
         reg1_data_q <= reg1_data_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         op2_addr_q <= 16'h0000;
      end else begin
         op2_addr_q <= op2_addr_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         op2_data_q <= 16'h0000;
      end else begin
         op2_data_q <= op2_data_d;
      end
   end

   // ----------------------------------------------------------------
   // Handshake outputs
   // ----------------------------------------------------------------
   assign ack_req             = ack_req_q;
   assign int_clear           = int_clear_q;

   // ----------------------------------------------------------------
   // Result outputs
   // ----------------------------------------------------------------
   assign program_status_word = status_q;
   assign exec_done           = done_q;
   assign branch_taken        = taken_q;
   assign reg1_we             = reg1_we_q;
   assign reg1_data           = reg1_data_q;
   assign reg2_we             = reg2_we_q;
   assign mem_we              = mem_we_q;
   assign op2_addr            = op2_addr_q;
   assign op2_data            = op2_data_q;

endmodule : branch_condition_and_int_ack

// *** inc/branch_ack_pkg.sv ***
/*
 Shared constants and carriers for the branch-condition and interrupt-acknowledge execution block.
 Assumes a single 20 MHz clock; every packed field lists its most significant part first.
*/
package branch_ack_pkg;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] op_branch_true  = 8'h42;
   localparam logic [7:0] op_branch_false = 8'h43;
   localparam logic [7:0] op_ack_reg      = 8'h9f;
   localparam logic [7:0] op_ack_indexed  = 8'hdf;

   // ----------------------------------------------------------------
   // Mask values and condition flag positions (C V G L)
   // ----------------------------------------------------------------
   localparam logic [3:0] mask_carry    = 4'h8;
   localparam logic [3:0] mask_overflow = 4'h4;
   localparam logic [3:0] mask_greater  = 4'h2;
   localparam logic [3:0] mask_less     = 4'h1;
   localparam logic [3:0] mask_zero_any = 4'h3;
   localparam int         flag_c_bit    = 3;
   localparam int         flag_v_bit    = 2;
   localparam int         flag_g_bit    = 1;
   localparam int         flag_l_bit    = 0;

   // ----------------------------------------------------------------
   // Status-derived flags: busy, check, end of medium, unavailable
   // ----------------------------------------------------------------
   localparam logic [3:0] flags_device_busy        = 4'h8;
   localparam logic [3:0] flags_check_status_flag  = 4'h4;
   localparam logic [3:0] flags_end_of_medium      = 4'h2;
   localparam logic [3:0] flags_device_unavailable = 4'h1;

   // ----------------------------------------------------------------
   // Word layout and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] next_instr_step = 16'h0004;
   localparam logic [3:0]  flags_reset     = 4'h0;
   localparam logic [15:0] addr_reset      = 16'h0000;
   localparam logic [7:0]  upper_byte_zero = 8'h00;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  opcode;
      logic [3:0]  mask_field;
      logic [3:0]  index_register_field;
      logic [15:0] displacement;
   } instr_type;

   typedef struct packed {
      logic [3:0]  condition_flags;
      logic [15:0] instr_addr;
   } status_word_type;

   typedef struct packed {
      logic [7:0] device_number;
      logic [7:0] status_byte;
   } ack_reply_type;

endpackage : branch_ack_pkg

// *** sim/branch_ack_sva.sv ***
/*
 Checker for the branch and acknowledge block.
 Assumes the top module ports; bound below.
*/
`timescale 1ns/1ps

module branch_ack_sva (
   // Clock and reset
   input wire logic                          clock,
   input wire logic                          rstn,
   // Issue side
   input wire logic                          exec_valid,
   input wire branch_ack_pkg::instr_type     instr,
   input wire logic [15:0]                   index_value,
   // Acknowledge handshake
   input wire logic                          ack_req,
   input wire logic                          ack_done,
   input wire branch_ack_pkg::ack_reply_type ack_reply,
   input wire logic                          int_clear,
   // Results
   input wire branch_ack_pkg::status_word_type program_status_word,
   input wire logic                          exec_done,
   input wire logic                          branch_taken,
   input wire logic                          reg1_we,
   input wire logic [15:0]                   reg1_data
);
   // ------------------------------------------
   // Issue tracking
   // ------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   logic busy_q;
   wire  is_br = instr.opcode == 8'h42 || instr.opcode == 8'h43;
   wire  is_ack = instr.opcode == 8'h9f || instr.opcode == 8'hdf;
   wire  go = exec_valid && !busy_q;
   wire  [3:0] sel = program_status_word.condition_flags & instr.mask_field;
   wire  want = (instr.opcode == 8'h42) ? (|sel) : !(|sel);
   // Busy spans the whole acknowledge so refused issues are not judged
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) busy_q <= 1'b0;
      else if (go && is_ack) busy_q <= 1'b1;
      else if (int_clear) busy_q <= 1'b0;
   end
   property p_decide; go && is_br |=> branch_taken == $past(want); endproperty
   property p_taken; go && is_br ##1 branch_taken |-> program_status_word.instr_addr ==
      $past(instr.displacement) + $past(index_value); endproperty
   property p_skip; go && is_br ##1 !branch_taken |-> program_status_word.instr_addr ==
      $past(program_status_word.instr_addr) + 16'h0004; endproperty
   property p_clear; ack_req && ack_done |=> int_clear && !ack_req; endproperty
   property p_cause; $rose(int_clear) |-> $past(ack_req && ack_done); endproperty
   property p_dev; ack_req && ack_done |=> reg1_we &&
      reg1_data == {8'h00, $past(ack_reply.device_number)}; endproperty
   property p_flags; ack_req && ack_done |=> program_status_word.condition_flags ==
      $past(ack_reply.status_byte[3:0]); endproperty
   property p_end; int_clear |=> exec_done && !int_clear && !branch_taken; endproperty
   a_decide: assert property (p_decide) else $error("branch decision wrong");
   a_taken: assert property (p_taken) else $error("taken address wrong");
   a_skip: assert property (p_skip) else $error("sequential address wrong");
   a_clear: assert property (p_clear) else $error("clear missing");
   a_cause: assert property (p_cause) else $error("stray clear");
   a_dev: assert property (p_dev) else $error("device number wrong");
   a_flags: assert property (p_flags) else $error("status flags wrong");
   a_end: assert property (p_end) else $error("end pulse wrong");
   c_taken: cover property (go && is_br ##1 branch_taken);
   c_skip: cover property (go && is_br ##1 !branch_taken);
   c_ack: cover property (int_clear);
endmodule : branch_ack_sva

bind branch_condition_and_int_ack branch_ack_sva u_sva (.clock(clock), .rstn(rstn),
   .exec_valid(exec_valid), .instr(instr), .index_value(index_value), .ack_req(ack_req),
   .ack_done(ack_done), .ack_reply(ack_reply), .int_clear(int_clear),
   .program_status_word(program_status_word), .exec_done(exec_done),
   .branch_taken(branch_taken), .reg1_we(reg1_we), .reg1_data(reg1_data));

// *** sim/int_device_model.sv ***
/*
 Interrupting peripheral on the acknowledge handshake.
 Assumes the bench sets the answer delay and reply.
*/
`timescale 1ns/1ps

module int_device_model (
   // Clock and reset
   input wire logic                          clock,
   input wire logic                          rstn,
   // Bench controls
   input wire logic [3:0]                    delay,
   input wire branch_ack_pkg::ack_reply_type reply,
   // Handshake
   input wire logic                          ack_req,
   input wire logic                          int_clear,
   output logic                              ack_done,
   output branch_ack_pkg::ack_reply_type     ack_reply,
   output logic                              pending
);
   logic [3:0] wait_q;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wait_q <= 4'h0;
         ack_done <= 1'b0;
         ack_reply <= 16'h0000;
         pending <= 1'b1;
      end else begin
         ack_done <= 1'b0;
         // Released reply toggles so a late sample cannot pass
         ack_reply <= ~ack_reply;
         if (int_clear) pending <= 1'b0;
         if (ack_req && !ack_done && wait_q == delay) begin
            ack_done <= 1'b1;
            ack_reply <= reply;
            wait_q <= 4'h0;
         end else if (ack_req && !ack_done) wait_q <= wait_q + 4'h1;
      end
   end
endmodule : int_device_model

// *** sim/branch_condition_and_int_ack_tb.sv ***
/*
 Self-checking bench for the branch and acknowledge block.
 Assumes the device model and the bound checker.
*/
`timescale 1ns/1ps

module branch_condition_and_int_ack_tb;
   logic clock, rstn, exec_valid, status_load, ack_done, int_clear, ack_req, pending;
   logic exec_done, branch_taken, reg1_we, reg2_we, mem_we;
   logic [15:0] index_value, reg1_data, op2_addr, op2_data;
   logic [3:0] delay;
   branch_ack_pkg::instr_type instr;
   branch_ack_pkg::status_word_type status_in, program_status_word;
   branch_ack_pkg::ack_reply_type ack_reply, reply;
   int fail_count, total_checks;
   branch_condition_and_int_ack uut (.clock(clock), .rstn(rstn), .exec_valid(exec_valid),
      .instr(instr), .index_value(index_value), .status_load(status_load),
      .status_in(status_in),
      .ack_req(ack_req), .ack_done(ack_done), .ack_reply(ack_reply), .int_clear(int_clear),
      .program_status_word(program_status_word), .exec_done(exec_done),
      .branch_taken(branch_taken), .reg1_we(reg1_we), .reg1_data(reg1_data),
      .reg2_we(reg2_we), .mem_we(mem_we), .op2_addr(op2_addr), .op2_data(op2_data));
   int_device_model dev (.clock(clock), .rstn(rstn), .delay(delay), .reply(reply),
      .ack_req(ack_req), .int_clear(int_clear), .ack_done(ack_done),
      .ack_reply(ack_reply), .pending(pending));
   // ------------------------------------------
   // Tasks
   // ------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic start(input logic [7:0] op, input logic [3:0] m, input logic [3:0] f);
      @(posedge clock);
      status_load <= 1'b1;
      status_in <= {f, 16'h0100};
      @(posedge clock);
      status_load <= 1'b0;
      exec_valid <= 1'b1;
      instr <= {op, m, 4'h1, 16'h2000};
      @(posedge clock);
      exec_valid <= 1'b0;
   endtask : start
   task automatic br(input logic [7:0] op, input logic [3:0] m, input logic [3:0] f,
                     input logic tk);
      start(op, m, f);
      // exec_done and branch_taken stand for one cycle only, right after the issue edge
      @(negedge clock);
      chk({10'h000, exec_done, branch_taken, program_status_word},
          {10'h000, 1'b1, tk, f, tk ? 16'h2010 : 16'h0104});
   endtask : br
   task automatic ack(input logic [7:0] op, input logic [3:0] dly, input logic [15:0] rp);
      int n;
      delay <= dly;
      reply <= rp;
      start(op, 4'h0, 4'hf);
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (reg1_we !== 1'b1 && n < 30);
      chk({reg1_we, int_clear, reg2_we, mem_we, ack_req, 11'h000, reg1_data},
          {2'b11, op == 8'h9f, op == 8'hdf, 12'h000, 8'h00, rp[15:8]});
      chk({op2_data, op2_addr}, {8'h00, rp[7:0], 16'h2010});
      chk({12'h000, program_status_word}, {12'h000, rp[3:0], 16'h0104});
      @(posedge clock);
      #1;
      chk({31'h0, exec_done}, {31'h0, 1'b1});
   endtask : ack
   task automatic tally_and_finish;
      if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   // ------------------------------------------
   // Sequence
   // ------------------------------------------
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      #(2000 * 50);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      {rstn, exec_valid, status_load, instr, status_in, delay, reply} = '0;
      index_value = 16'h0010;
      fail_count = 0;
      total_checks = 0;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      br(8'h42, 4'h3, 4'h2, 1'b1);
      br(8'h42, 4'h3, 4'h0, 1'b0);
      br(8'h42, 4'h2, 4'h2, 1'b1);
      br(8'h42, 4'h2, 4'hd, 1'b0);
      br(8'h43, 4'h2, 4'h2, 1'b0);
      br(8'h43, 4'h2, 4'hd, 1'b1);
      br(8'h42, 4'h1, 4'h1, 1'b1);
      br(8'h42, 4'h1, 4'he, 1'b0);
      br(8'h43, 4'h1, 4'h0, 1'b1);
      br(8'h43, 4'h1, 4'h1, 1'b0);
      br(8'h42, 4'h8, 4'h8, 1'b1);
      br(8'h42, 4'h8, 4'h7, 1'b0);
      br(8'h42, 4'h4, 4'h4, 1'b1);
      br(8'h42, 4'h4, 4'hb, 1'b0);
      br(8'h43, 4'h8, 4'h8, 1'b0);
      br(8'h43, 4'h8, 4'h7, 1'b1);
      br(8'h43, 4'h3, 4'hc, 1'b1);
      br(8'h43, 4'h3, 4'h1, 1'b0);
      br(8'h42, 4'h3, 4'h1, 1'b1);
      br(8'h42, 4'h0, 4'hf, 1'b0);
      br(8'h42, 4'h6, 4'h4, 1'b1);
      br(8'h43, 4'h6, 4'h4, 1'b0);
      chk({31'h0, pending}, {31'h0, 1'b1});
      ack(8'h9f, 4'h0, 16'h5a38);
      chk({31'h0, pending}, {31'h0, 1'b0});
      ack(8'hdf, 4'h5, 16'h07a4);
      for (int i = 0; i < 4; i++) begin
         ack(8'h9f, 4'h2, {8'h30, 8'h08 >> i});
      end
      ack(8'hdf, 4'h1, 16'hc3f0);
      tally_and_finish();
   end
endmodule : branch_condition_and_int_ack_tb
